/* File: inc/xpt_pkg.sv */
// Shared constants and types of the crosspoint serial control block.
`default_nettype none
package xpt_pkg;
    localparam int         BYTE_W      = 8;
    localparam int         FRAME_BITS  = 16;
    localparam int         NUM_OUT     = 4;
    localparam int         SW_W        = 5;
    localparam int         SIDE_W      = 4;
    localparam int         CMD_AUX     = 4;
    localparam int         CMD_MODE    = 5;
    localparam int         MODE_POS    = 4;
    localparam int         BIAS_POS    = 0;
    localparam logic [3:0] ACK_AT      = 4'h8;
    localparam logic [4:0] DEV_ADDR_HI = 5'h13;
    localparam logic [4:0] SW_RESET    = 5'h10;
    localparam logic [3:0] SIDE_RESET  = 4'h0;
    localparam logic [3:0] CLICK_RESET = 4'hf;
    localparam logic [3:0] BIAS_RESET  = 4'h0;
    localparam logic [3:0] TW_SYNC_INIT = 4'hc;
    localparam logic [2:0] TH_SYNC_INIT = 3'h4;

    typedef enum logic [2:0] {
        TW_IDLE,
        TW_ADDR,
        TW_CMD,
        TW_DATA,
        TW_SKIP
    } tw_state_t;
endpackage : xpt_pkg
`default_nettype wire

/* File: inc/cmd_if.sv */
// Command and data word handed from a serial front end to the registers.
`timescale 1ns/100ps
`default_nettype none
interface cmd_if;
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] data;
    modport src (output valid, output cmd, output data);
    modport dst (input valid, input cmd, input data);
endinterface : cmd_if
`default_nettype wire

/* File: design/sync_edge.sv */
// Two-stage pin synchroniser with edge detection after the second stage.
`timescale 1ns/100ps
`default_nettype none
module sync_edge #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,    // System clock.
    input  wire logic         rst_n,  // Synchronous reset, active low.
    input  wire logic [W-1:0] pin_in, // Asynchronous pin levels.
    output logic      [W-1:0] level,  // Synchronised levels.
    output logic      [W-1:0] rise,   // One-cycle rising edge pulses.
    output logic      [W-1:0] fall    // One-cycle falling edge pulses.
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] stable_reg;
    logic [W-1:0] last_reg;

    // Reset to the idle pin level so that release makes no false edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg   <= INIT;
            stable_reg <= INIT;
            last_reg   <= INIT;
        end else begin
            meta_reg   <= pin_in;
            stable_reg <= meta_reg;
            last_reg   <= stable_reg;
        end
    end

    assign level = stable_reg;
    assign rise  = stable_reg & ~last_reg;
    assign fall  = ~stable_reg & last_reg;
endmodule : sync_edge
`default_nettype wire

/* File: design/threewire_rx.sv */
// Three-wire shift port: 16-bit frame, delayed serial output, load on deselect.
`timescale 1ns/100ps
`default_nettype none
module threewire_rx
    import xpt_pkg::*;
(
    input  wire logic clk,         // System clock.
    input  wire logic rst_n,       // Synchronous reset, active low.
    input  wire logic select_n,    // Port select pin, active low.
    input  wire logic shift_clock, // Shift clock pin.
    input  wire logic serial_in,   // Serial data pin.
    output logic      serial_out,  // Delayed serial data for chaining.
    cmd_if.src        frame        // Completed command word.
);
    logic [2:0]            lvl;
    logic [2:0]            rise;
    logic [2:0]            fall;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [4:0]            cnt_reg;
    logic                  out_reg;
    logic                  sel_low;
    logic                  sh_rise;

    sync_edge #(.W(3), .INIT(TH_SYNC_INIT)) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_in ({select_n, shift_clock, serial_in}),
        .level  (lvl),
        .rise   (rise),
        .fall   (fall)
    );

    assign sel_low = !lvl[2];
    assign sh_rise = rise[1] && sel_low;

    always_ff @(posedge clk) begin
        if (!rst_n) shift_reg <= '0;
        else if (sh_rise) shift_reg <= {shift_reg[FRAME_BITS-2:0], lvl[0]}; // R13 R15
    end

    // The count saturates so a long daisy chain still loads its last word.
    always_ff @(posedge clk) begin
        if (!rst_n) cnt_reg <= '0;
        else if (rise[2]) cnt_reg <= '0;
        else if (sh_rise && cnt_reg != 5'(FRAME_BITS)) cnt_reg <= cnt_reg + 5'h01;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) out_reg <= 1'b0;
        else if (fall[1] && sel_low) out_reg <= shift_reg[FRAME_BITS-1]; // R18 R19
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame.valid <= 1'b0;
            frame.cmd   <= '0;
            frame.data  <= '0;
        end else begin
            frame.valid <= rise[2] && cnt_reg == 5'(FRAME_BITS); // R17
            if (rise[2]) begin
                frame.cmd  <= shift_reg[FRAME_BITS-1:BYTE_W];
                frame.data <= shift_reg[BYTE_W-1:0];
            end
        end
    end

    assign serial_out = out_reg;

    a_idle_frozen: assert property (@(posedge clk) disable iff (!rst_n) // R19
        lvl[2] |=> $stable(shift_reg) && $stable(out_reg))
        else $error("shift state moved while deselected");
    a_frame_load: assert property (@(posedge clk) disable iff (!rst_n) // R17
        rise[2] && cnt_reg == 5'(FRAME_BITS)
        |=> frame.valid && frame.data == $past(shift_reg[BYTE_W-1:0]))
        else $error("full frame not loaded on deselect");
endmodule : threewire_rx
`default_nettype wire

/* File: design/crosspoint_serial_control.sv */
// Crosspoint control: 2-wire and 3-wire command ports and output registers.
//
// Function
// R01: Command bits 0 to 3 load the data byte into the selected outputs.
// R02: Matrix byte bits 0-3 close inputs 1-4, bit 4 the shunt.
// R03: Side byte bits 0-3 drive side outputs 0-3; upper bits ignored.
// R04: Mode byte bits 4-7 enable clickless switching per output.
// R05: Mode byte bits 0-3 connect the bias network per output.
// R06: Command bit 4 selects the side output register.
// R07: Command bit 5 selects the clickless and bias register.
// R08: A 2-wire transfer is start, address, command, data, stop.
// R09: The device acknowledges address, command and data bytes for one clock.
// R10: Start and stop are SDA edges while SCL is high.
// R11: Only address 10011, high strap, low strap, zero is answered.
// R12: The 2-wire port is write only; SDA is driven only to acknowledge.
// R13: The 3-wire port samples serial data on clock rise while selected.
// R14: The controller supplies 16 bits per frame, maybe in two bytes.
// R15: Frame order is command MSB first, data LSB last.
// R16: Outputs keep their state while bits are shifted in.
// R17: Deselect after 16 bits loads and applies the frame.
// R18: Serial output is the input delayed 16 clocks, on falling edges.
// R19: While deselected, shifting stops and the serial output holds.
// R20: Chained devices get 16 bits each and update together.
// R21: Reset connects every output to its shunt, clickless, no bias, sides low.
// R22: Several command bits write the same byte; others stay; bits 6-7 ignored.
// R23: A wrong address is not acknowledged; aborted transfers change nothing.
// R24: 2-wire commands apply after the data byte is acknowledged.
`timescale 1ns/100ps
`default_nettype none
module crosspoint_serial_control
    import xpt_pkg::*;
(
    input  wire logic          clk,            // System clock, 100 MHz.
    input  wire logic          rst_n,          // Synchronous reset, low.
    input  wire logic          scl,            // 2-wire clock pin.
    input  wire logic          sda_in,         // 2-wire data pin level.
    output logic               sda_out,        // 2-wire data drive value.
    output logic               sda_oe,         // 2-wire data drive enable.
    input  wire logic          addr_strap_hi,  // Upper address strap pin.
    input  wire logic          addr_strap_lo,  // Lower address strap pin.
    input  wire logic          select_n,       // 3-wire select, active low.
    input  wire logic          shift_clock,    // 3-wire shift clock pin.
    input  wire logic          serial_in,      // 3-wire data in.
    output logic               serial_out,     // 3-wire delayed data out.
    output logic [SW_W-1:0]    out1_matrix_a,  // Switches of A output 1.
    output logic [SW_W-1:0]    out2_matrix_a,  // Switches of A output 2.
    output logic [SW_W-1:0]    out1_matrix_b,  // Switches of B output 1.
    output logic [SW_W-1:0]    out2_matrix_b,  // Switches of B output 2.
    output logic [NUM_OUT-1:0] clickless_en,   // Clickless mode per output.
    output logic [NUM_OUT-1:0] bias_en,        // Bias network per output.
    output logic               side_out_0,     // Side logic output 0.
    output logic               side_out_1,     // Side logic output 1.
    output logic               side_out_2,     // Side logic output 2.
    output logic               side_out_3      // Side logic output 3.
);
    cmd_if frame3 ();

    logic [3:0]         tw_lvl;
    logic [3:0]         tw_rise;
    logic [3:0]         tw_fall;
    logic               scl_rise;
    logic               scl_fall;
    logic               tw_start;
    logic               tw_stop;
    logic               receiving;
    logic               byte_done;
    logic               match;
    tw_state_t          state_reg;
    logic [3:0]         bit_cnt_reg;
    logic [7:0]         rx_reg;
    logic [7:0]         cmd_reg;
    logic [7:0]         data_reg;
    logic               ack_reg;
    logic               tw_apply_reg;
    logic               apply_valid;
    logic [7:0]         apply_cmd;
    logic [7:0]         apply_data;
    logic [SIDE_W-1:0]  side_reg;
    logic [NUM_OUT-1:0] click_reg;
    logic [NUM_OUT-1:0] bias_reg;

    function automatic logic addr_hit(input logic [7:0] b,
                                      input logic       hi,
                                      input logic       lo);
        return b == {DEV_ADDR_HI, hi, lo, 1'b0};
    endfunction : addr_hit

    // Both ports share one synchroniser style; straps pass it as well.
    sync_edge #(.W(4), .INIT(TW_SYNC_INIT)) u_tw_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_in ({scl, sda_in, addr_strap_hi, addr_strap_lo}),
        .level  (tw_lvl),
        .rise   (tw_rise),
        .fall   (tw_fall)
    );

    threewire_rx u_three (
        .clk         (clk),
        .rst_n       (rst_n),
        .select_n    (select_n),
        .shift_clock (shift_clock),
        .serial_in   (serial_in),
        .serial_out  (serial_out),
        .frame       (frame3)
    );

    assign scl_rise  = tw_rise[3];
    assign scl_fall  = tw_fall[3];
    assign tw_start  = tw_lvl[3] && tw_fall[2]; // R10
    assign tw_stop   = tw_lvl[3] && tw_rise[2]; // R10
    assign byte_done = bit_cnt_reg == ACK_AT;
    assign match     = addr_hit(rx_reg, tw_lvl[1], tw_lvl[0]); // R11
    assign receiving = state_reg == TW_ADDR || state_reg == TW_CMD
                       || state_reg == TW_DATA;

    // Transfer sequence; extra bytes after the data byte are not taken.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= TW_IDLE;
        end else if (tw_stop) begin
            state_reg <= TW_IDLE;
        end else if (tw_start) begin
            state_reg <= TW_ADDR; // R08
        end else if (scl_fall) begin
            case (state_reg)
                TW_ADDR: begin
                    if (ack_reg) state_reg <= TW_CMD;
                    else if (byte_done && !match) state_reg <= TW_SKIP; // R23
                end
                TW_CMD: begin
                    if (ack_reg) state_reg <= TW_DATA; // R08
                end
                TW_DATA: begin
                    if (ack_reg) state_reg <= TW_SKIP;
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_cnt_reg <= '0;
        end else if (tw_start || (scl_fall && ack_reg)) begin
            bit_cnt_reg <= '0;
        end else if (scl_rise && receiving && !byte_done && !ack_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_reg <= '0;
        end else if (scl_rise && receiving && !byte_done && !ack_reg) begin
            rx_reg <= {rx_reg[6:0], tw_lvl[2]};
        end
    end

    // The acknowledge spans SCL low, high, and ends on the next fall.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else if (tw_start || tw_stop) begin
            ack_reg <= 1'b0;
        end else if (scl_fall) begin
            if (ack_reg) ack_reg <= 1'b0;
            else if (byte_done && receiving
                     && (state_reg != TW_ADDR || match)) ack_reg <= 1'b1; // R09
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_reg  <= '0;
            data_reg <= '0;
        end else if (scl_fall && !ack_reg && byte_done) begin
            if (state_reg == TW_CMD) cmd_reg <= rx_reg;
            if (state_reg == TW_DATA) data_reg <= rx_reg;
        end
    end

    // Applying only after the last acknowledge keeps aborted transfers inert.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tw_apply_reg <= 1'b0;
        end else begin
            tw_apply_reg <= scl_fall && ack_reg && state_reg == TW_DATA
                            && !tw_start && !tw_stop; // R24 R23
        end
    end

    // The device only ever pulls low, so the drive value is fixed.
    assign sda_out = 1'b0; // R12
    assign sda_oe  = ack_reg; // R12

    // Both ports may finish together only by misuse; the 2-wire word wins.
    assign apply_valid = tw_apply_reg || frame3.valid;
    assign apply_cmd   = tw_apply_reg ? cmd_reg : frame3.cmd;
    assign apply_data  = tw_apply_reg ? data_reg : frame3.data;

    // Registers move only on a completed word, never during shifting.
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_sw
        logic [SW_W-1:0] sw_reg;
        always_ff @(posedge clk) begin
            if (!rst_n) sw_reg <= SW_RESET; // R21
            else if (apply_valid && apply_cmd[i])
                sw_reg <= apply_data[SW_W-1:0]; // R01 R02 R22 R16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) side_reg <= SIDE_RESET; // R21
        else if (apply_valid && apply_cmd[CMD_AUX])
            side_reg <= apply_data[SIDE_W-1:0]; // R06 R03
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            click_reg <= CLICK_RESET; // R21
            bias_reg  <= BIAS_RESET; // R21
        end else if (apply_valid && apply_cmd[CMD_MODE]) begin
            click_reg <= apply_data[MODE_POS+:NUM_OUT]; // R07 R04
            bias_reg  <= apply_data[BIAS_POS+:NUM_OUT]; // R05
        end
    end

    assign out1_matrix_a = g_sw[0].sw_reg;
    assign out2_matrix_a = g_sw[1].sw_reg;
    assign out1_matrix_b = g_sw[2].sw_reg;
    assign out2_matrix_b = g_sw[3].sw_reg;
    assign clickless_en  = click_reg;
    assign bias_en       = bias_reg;
    assign side_out_0    = side_reg[0];
    assign side_out_1    = side_reg[1];
    assign side_out_2    = side_reg[2];
    assign side_out_3    = side_reg[3];

    a_matrix_load: assert property (@(posedge clk) disable iff (!rst_n) // R01
        apply_valid && apply_cmd[2]
        |=> out1_matrix_b == $past(apply_data[SW_W-1:0]))
        else $error("selected matrix output not loaded");

    a_matrix_keep: assert property (@(posedge clk) disable iff (!rst_n) // R22
        !(apply_valid && apply_cmd[0]) |=> $stable(out1_matrix_a))
        else $error("unselected matrix output changed");

    a_side_load: assert property (@(posedge clk) disable iff (!rst_n) // R06
        apply_valid && apply_cmd[CMD_AUX]
        |=> side_out_3 == $past(apply_data[3]) && side_out_0 == $past(apply_data[0]))
        else $error("side outputs not loaded");

    a_mode_load: assert property (@(posedge clk) disable iff (!rst_n) // R07
        apply_valid && apply_cmd[CMD_MODE]
        |=> clickless_en == $past(apply_data[7:4])
            && bias_en == $past(apply_data[3:0]))
        else $error("mode and bias not loaded");

    a_reset_state: assert property (@(posedge clk) // R21
        !rst_n |=> out2_matrix_b == SW_RESET && clickless_en == CLICK_RESET
                   && bias_en == BIAS_RESET && !side_out_1)
        else $error("power-up state wrong");

    a_ack_only: assert property (@(posedge clk) disable iff (!rst_n) // R12
        sda_oe |-> !sda_out && (state_reg != TW_IDLE))
        else $error("data line driven outside an acknowledge");

    a_ack_hold: assert property (@(posedge clk) disable iff (!rst_n) // R09
        ack_reg && !scl_fall && !tw_start && !tw_stop |=> ack_reg)
        else $error("acknowledge released before clock fall");

    a_ack_bound: assert property (@(posedge clk) disable iff (!rst_n) // R09
        $rose(ack_reg) && tw_lvl[3] == 1'b0 |-> ##[1:1000] !ack_reg)
        else $error("acknowledge never released");

    a_skip_silent: assert property (@(posedge clk) disable iff (!rst_n) // R23
        state_reg == TW_SKIP && $past(state_reg) == TW_SKIP |-> !sda_oe)
        else $error("acknowledge after mismatch or extra byte");

    a_apply_ack: assert property (@(posedge clk) disable iff (!rst_n) // R24
        tw_apply_reg |-> $past(ack_reg) && $past(state_reg) == TW_DATA)
        else $error("2-wire word applied before data acknowledge");

    a_stop_idle: assert property (@(posedge clk) disable iff (!rst_n) // R10
        tw_stop |=> state_reg == TW_IDLE && !ack_reg)
        else $error("stop condition not honoured");

    a_shift_quiet: assert property (@(posedge clk) disable iff (!rst_n) // R16
        !apply_valid |=> $stable(side_reg) && $stable(click_reg)
                         && $stable(bias_reg))
        else $error("state changed without a completed word");

    a_addr_refuse: assert property (@(posedge clk) disable iff (!rst_n) // R11
        state_reg == TW_ADDR && scl_fall && byte_done && !ack_reg && !match
        |=> state_reg == TW_SKIP && !ack_reg)
        else $error("wrong address acknowledged");

    a_start_addr: assert property (@(posedge clk) disable iff (!rst_n) // R10
        tw_start
        |=> state_reg == TW_ADDR && bit_cnt_reg == 4'h0 && !ack_reg)
        else $error("start condition not honoured");

    a_ack_cause: assert property (@(posedge clk) disable iff (!rst_n) // R09
        $rose(ack_reg)
        |-> $past(scl_fall && byte_done && receiving))
        else $error("acknowledge without a received byte");

    a_cmd_capture: assert property (@(posedge clk) disable iff (!rst_n) // R08
        scl_fall && !ack_reg && byte_done && state_reg == TW_CMD
        |=> cmd_reg == $past(rx_reg))
        else $error("command byte not captured");

    a_tw_side: assert property (@(posedge clk) disable iff (!rst_n) // R24
        tw_apply_reg && cmd_reg[CMD_AUX]
        |=> side_reg == $past(data_reg[SIDE_W-1:0]))
        else $error("2-wire word not applied to side outputs");

    // The 3-wire word only counts when no 2-wire word wins the same cycle.
    a_three_apply: assert property (@(posedge clk) disable iff (!rst_n) // R17
        frame3.valid && !tw_apply_reg && frame3.cmd[1]
        |=> out2_matrix_a == $past(frame3.data[SW_W-1:0]))
        else $error("3-wire word not applied");

    a_click_keep: assert property (@(posedge clk) disable iff (!rst_n) // R22
        !(apply_valid && apply_cmd[CMD_MODE])
        |=> $stable(clickless_en) && $stable(bias_en))
        else $error("unselected mode or bias changed");

    c_tw_write: cover property (@(posedge clk) disable iff (!rst_n)
        tw_apply_reg);
    c_three_write: cover property (@(posedge clk) disable iff (!rst_n)
        frame3.valid);
    c_addr_miss: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == TW_ADDR ##1 state_reg == TW_SKIP);
    c_multi_sel: cover property (@(posedge clk) disable iff (!rst_n)
        apply_valid && apply_cmd[0] && apply_cmd[3] && apply_cmd[CMD_MODE]);
    c_tw_abort: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == TW_DATA ##1 state_reg == TW_IDLE);
endmodule : crosspoint_serial_control
`default_nettype wire

/* File: test/bus_master_model.sv */
// Bus master model that drives the 2-wire and 3-wire ports.
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
    output logic      scl,         // 2-wire clock.
    output logic      sda_drv,     // 2-wire data, 1 releases the line.
    input  wire logic sda_wire,    // Resolved 2-wire data line.
    output logic      select_n,    // 3-wire select, active low.
    output logic      shift_clock, // 3-wire shift clock.
    output logic      serial_in,   // 3-wire data.
    input  wire logic serial_out   // 3-wire chained data.
);
    localparam real H = 62.5;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        select_n = 1'b1;
        shift_clock = 1'b0;
        serial_in = 1'b0;
    end
    // Data moves a quarter period after SCL falls so it never looks
    // like a start or stop to a synchronised receiver.
    // Tasks start 1 ns late and quarter steps alternate 31.2 and 31.3 ns, so
    // no pin edge ever meets a rising edge of the system clock.
    task automatic tw_bit(input logic b, output logic seen);
        #31.2 sda_drv = b;
        #31.3 scl = 1'b1;
        #31.2 seen = sda_wire;
        #31.3 scl = 1'b0;
    endtask : tw_bit
    task automatic tw_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) tw_bit(b[i], s);
        tw_bit(1'b1, s);
        ack = ~s;
    endtask : tw_byte
    task automatic tw_frame(input logic [7:0] a, c, d, input int nb,
                            output logic [2:0] acks);
        acks = 3'h0;
        #(H + 1) sda_drv = 1'b0;
        #H scl = 1'b0;
        tw_byte(a, acks[2]);
        if (nb > 1) tw_byte(c, acks[1]);
        if (nb > 2) tw_byte(d, acks[0]);
        #31.2 sda_drv = 1'b0;
        #31.3 scl = 1'b1;
        #H sda_drv = 1'b1;
        #H;
    endtask : tw_frame
    task automatic th_bits(input logic [31:0] w, input int n,
                           input logic seg, output logic [31:0] so);
        so = '0;
        #1 select_n = 1'b0;
        for (int r = 0; r < n; r++) begin
            if (seg && r == 8) #(4 * H);
            serial_in = w[n - 1 - r];
            #H so[r] = serial_out;
            shift_clock = 1'b1;
            #H shift_clock = 1'b0;
        end
    endtask : th_bits
    // After deselect the data line is inverted, so it shows a changed level.
    task automatic th_end;
        #(H + 1) select_n = 1'b1;
        serial_in = ~serial_in;
        #H;
    endtask : th_end
    task automatic th_idle;
        #1;
        repeat (8) begin
            serial_in = ~serial_in;
            #H shift_clock = 1'b1;
            #H shift_clock = 1'b0;
        end
    endtask : th_idle
endmodule : bus_master_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the crosspoint serial control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import xpt_pkg::*;
    logic              clk, rst_n, strap_hi, strap_lo, scl, sda_drv;
    logic              sda_out, sda_oe, select_n, shift_clock, serial_in;
    logic              serial_out, side_out_0, side_out_1;
    logic              side_out_2, side_out_3;
    // Shift contents left by the 15-bit test, then the chained 32-bit word.
    logic [47:0]       chain_bits = 48'h7fff_3fff_1005;
    logic [SW_W-1:0]   out1_matrix_a, out2_matrix_a;
    logic [SW_W-1:0]   out1_matrix_b, out2_matrix_b;
    logic [3:0]        clickless_en, bias_en, ec, eb, es;
    logic [SW_W-1:0]   em [4];
    logic [2:0]        acks;
    logic [31:0]       so;
    logic [7:0]        dtab [6] = '{8'hea, 8'h57, 8'hf3, 8'h2c, 8'hf9, 8'h6d};
    wire               sda_line;
    int                error_cnt = 0;
    int                n_compared = 0;
    int                cyc = 0;
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
    crosspoint_serial_control u_crosspoint_serial_control (
        .clk, .rst_n, .scl, .sda_in(sda_line), .sda_out, .sda_oe,
        .addr_strap_hi(strap_hi), .addr_strap_lo(strap_lo), .select_n,
        .shift_clock, .serial_in, .serial_out, .out1_matrix_a,
        .out2_matrix_a, .out1_matrix_b, .out2_matrix_b, .clickless_en,
        .bias_en, .side_out_0, .side_out_1, .side_out_2, .side_out_3);
    bus_master_model u_bus_master_model (
        .scl, .sda_drv, .sda_wire(sda_line), .select_n, .shift_clock,
        .serial_in, .serial_out);
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [31:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic chk(input string what);
        cmp({out1_matrix_a, out2_matrix_a, out1_matrix_b, out2_matrix_b,
             clickless_en, bias_en, side_out_3, side_out_2, side_out_1,
             side_out_0}, {em[0], em[1], em[2], em[3], ec, eb, es}, what);
    endtask : chk
    task automatic exp_apply(input logic [7:0] c, d);
        for (int i = 0; i < 4; i++) if (c[i]) em[i] = d[4:0];
        if (c[CMD_AUX]) es = d[3:0];
        if (c[CMD_MODE]) ec = d[7:4];
        if (c[CMD_MODE]) eb = d[3:0];
    endtask : exp_apply
    task automatic tw(input logic [7:0] a, c, d, input int nb,
                      input logic [2:0] eacks);
        u_bus_master_model.tw_frame(a, c, d, nb, acks);
        cmp(acks, eacks, "2-wire acknowledges");
        if (eacks == 3'h7) exp_apply(c, d);
        repeat (10) @(negedge clk);
        chk("2-wire outputs");
    endtask : tw
    task automatic th(input logic [31:0] w, input int n, input logic seg);
        u_bus_master_model.th_bits(w, n, seg, so);
        repeat (10) @(negedge clk);
        chk("outputs while shifting");
        u_bus_master_model.th_end();
        if (n >= 16) exp_apply(w[15:8], w[7:0]);
        repeat (10) @(negedge clk);
        chk("3-wire outputs");
    endtask : th
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n = 1'b0;
        strap_hi = 1'b0;
        strap_lo = 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (4) @(negedge clk);
        em = '{SW_RESET, SW_RESET, SW_RESET, SW_RESET};
        ec = CLICK_RESET;
        eb = BIAS_RESET;
        es = SIDE_RESET;
        chk("reset state");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            tw({DEV_ADDR_HI, 3'h2}, 8'h01 << i, dtab[i], 3, 3'h7);
        end
        $display("test 2-wire commands done");
        @(negedge clk) strap_hi = 1'b1;
        strap_lo = 1'b0;
        repeat (4) @(negedge clk);
        tw({DEV_ADDR_HI, 3'h4}, 8'hcc, 8'h0b, 3, 3'h7);
        tw({DEV_ADDR_HI, 3'h2}, 8'h3f, 8'hff, 3, 3'h0);
        tw({DEV_ADDR_HI, 3'h5}, 8'h3f, 8'hff, 3, 3'h0);
        tw({DEV_ADDR_HI, 3'h4}, 8'h3f, 8'hff, 2, 3'h6);
        $display("test 2-wire refusals done");
        th(32'h2196, 16, 1'b0);
        th(32'h1f0e, 16, 1'b1);
        th(32'h7fff, 15, 1'b0);
        cmp(32'(serial_out), 32'(chain_bits[47]), "last bit held");
        u_bus_master_model.th_idle();
        repeat (10) @(negedge clk);
        cmp(32'(serial_out), 32'(chain_bits[47]), "out deselected");
        chk("outputs while deselected");
        $display("test 3-wire done");
        th(32'h3fff_1005, 32, 1'b0);
        for (int k = 0; k < 16; k++) begin
            cmp(32'(so[k]), 32'(chain_bits[47 - k]), "old bits out");
        end
        for (int k = 16; k < 32; k++) begin
            cmp(32'(so[k]), 32'(chain_bits[47 - k]), "serial out");
        end
        $display("test chain done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
